// File: include/mit_pkg.sv
// Constants, types and word packing for the monitored input block
package mit_pkg;

// Behaviour
// R1: Each pass forces every input low, then high, and checks both levels are seen.
// R2: A pass starts once per second and finishes in under one millisecond.
// R3: An input missing either forced level is flagged faulty and the indicator flashes.
// R4: Forcing leaves the field source alone; reported states never show forced levels.
// R5: All inputs are digitally filtered so glitches change no state and no flag; a glitch in the last three samples of a phase flags a fault.
// R6: Four words are presented: two state words, then two fault words.
// R7: A state bit is 1 while its input is on, 0 while off.
// R8: A fault bit is 1 while its input is faulty, 0 while functional.
// R9: An open, unconnected input reads 0 in its state bit.
// R10: Loss of field supply sets all 32 fault bits to 1.
// R11: On field supply return fault bits clear once inputs pass diagnostics.
// R12: Indicator is steady on without faults and blinks while any fault exists.
// R13: Input 1 sits at bit 1 of first state and fault words; same positions.
// R14: Inputs 1-16 in first word, 17-32 in second; bit 1 is MSB.
// R15: Fault flags update at each pass end and hold until a later pass succeeds.

  localparam int CLK_HZ          = 40_000_000;
  localparam int PASS_PERIOD_MS  = 1000;
  localparam int PASS_PERIOD_CYC = CLK_HZ / 1000 * PASS_PERIOD_MS;
  localparam int PHASE_US        = 400;
  localparam int PHASE_CYC       = CLK_HZ / 1_000_000 * PHASE_US;
  localparam int FILT_US         = 5000;
  localparam int FILT_CYC        = CLK_HZ / 1_000_000 * FILT_US;
  localparam int BLINK_MS        = 250;
  localparam int BLINK_CYC       = CLK_HZ / 1000 * BLINK_MS;

  localparam int N_IN   = 32;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 8;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] A_STATE_LO = 8'h00;
  localparam logic [ADDR_W-1:0] A_STATE_HI = 8'h04;
  localparam logic [ADDR_W-1:0] A_FAULT_LO = 8'h08;
  localparam logic [ADDR_W-1:0] A_FAULT_HI = 8'h0C;
  localparam logic [ADDR_W-1:0] A_CTRL     = 8'h10;
  localparam logic [ADDR_W-1:0] A_STATUS   = 8'h14;

  // Control and status fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_GO_BIT   = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_FIELD_BIT  = 1;
  localparam int ST_FAULT_BIT  = 2;
  localparam int ST_CNT_LSB    = 8;
  localparam int CNT_W         = 8;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_LOW  = 2'b01,
    SEQ_HIGH = 2'b10,
    SEQ_DONE = 2'b11
  } seq_state_t;

  // Input 1 lands in the MSB of the first word, input 16 in its LSB
  function automatic logic [WORD_W-1:0] pack_word(input logic [N_IN-1:0] v,
                                                  input logic            hi);
    logic [WORD_W-1:0] r;
    r = '0;
    for (int i = 0; i < WORD_W; i++) begin
      r[WORD_W-1-i] = hi ? v[WORD_W+i] : v[i];
    end
    return r;
  endfunction : pack_word

endpackage : mit_pkg

// File: hdl/input_filter.sv
// Per-input digital filter with a freeze input
`timescale 1ns/1ps
module input_filter import mit_pkg::*; #(
  parameter int N   = N_IN,
  parameter int CNT = FILT_CYC
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         hold,
  input  wire logic [N-1:0] raw,
  output logic      [N-1:0] filt
);

  localparam int CW = $clog2(CNT + 1);

  logic [CW-1:0] cnt [N];

  // A level must differ for CNT straight cycles before it is taken;
  // while held the count restarts, so forced levels never leak through
  always_ff @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      if (rst) begin
        cnt[i]  <= '0;
        filt[i] <= 1'b0;
      end else if (hold || raw[i] == filt[i]) begin // [R4] [R5]
        cnt[i] <= '0;
      end else if (cnt[i] == CW'(CNT - 1)) begin
        cnt[i]  <= '0;
        filt[i] <= raw[i];
      end else begin
        cnt[i] <= cnt[i] + 1'b1;
      end
    end
  end

endmodule : input_filter

// File: hdl/self_test_seq.sv
// Diagnostic pass timer and force sequencer
`timescale 1ns/1ps
module self_test_seq import mit_pkg::*; #(
  parameter int PERIOD = PASS_PERIOD_CYC,
  parameter int PHASE  = PHASE_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic go,
  output logic      force_low,
  output logic      force_high,
  output logic      sample_low,
  output logic      done,
  output logic      busy
);

  localparam int PW = $clog2(PERIOD + 1);
  localparam int HW = $clog2(PHASE + 1);

  seq_state_t    state;
  logic [PW-1:0] per_cnt;
  logic [HW-1:0] ph_cnt;
  logic          tick;
  logic          ph_end;
  logic          ph_pre;

  assign tick   = (per_cnt == PW'(PERIOD - 1));
  assign ph_end = (ph_cnt == HW'(PHASE - 1));
  // One cycle before the phase ends: the strobes it launches stand in the
  // last cycle of the phase, while the forced level is still on the pins
  assign ph_pre = (ph_cnt == HW'(PHASE - 2));

  // Free-running one second timer
  always_ff @(posedge clk) begin
    if (rst || tick) begin
      per_cnt <= '0;
    end else begin
      per_cnt <= per_cnt + 1'b1;
    end
  end

  // Two forced phases, both well inside one millisecond
  always_ff @(posedge clk) begin
    if (rst) begin
      state      <= SEQ_IDLE;
      ph_cnt     <= '0;
      force_low  <= 1'b0;
      force_high <= 1'b0;
      sample_low <= 1'b0;
      done       <= 1'b0;
      busy       <= 1'b0;
    end else begin
      sample_low <= 1'b0;
      done       <= 1'b0;
      unique case (state)
        SEQ_IDLE: begin
          ph_cnt <= '0;
          if (enable && (tick || go)) begin // [R2]
            state     <= SEQ_LOW;
            force_low <= 1'b1; // [R1]
            busy      <= 1'b1;
          end
        end
        SEQ_LOW: begin
          ph_cnt <= ph_end ? '0 : ph_cnt + 1'b1;
          if (ph_pre) begin
            sample_low <= 1'b1; // [R1]
          end
          if (ph_end) begin
            state      <= SEQ_HIGH;
            force_low  <= 1'b0;
            force_high <= 1'b1; // [R1]
          end
        end
        SEQ_HIGH: begin
          ph_cnt <= ph_end ? '0 : ph_cnt + 1'b1;
          if (ph_pre) begin
            done <= 1'b1; // [R2]
          end
          if (ph_end) begin
            state      <= SEQ_DONE;
            force_high <= 1'b0;
          end
        end
        SEQ_DONE: begin
          state <= SEQ_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

endmodule : self_test_seq

// File: hdl/monitored_input_self_test.sv
// Top of the 32-input monitored input block with APB register access
`timescale 1ns/1ps
module monitored_input_self_test import mit_pkg::*; #(
  parameter int PERIOD_CYC = PASS_PERIOD_CYC,
  parameter int TEST_CYC   = PHASE_CYC,
  parameter int FILTER_CYC = FILT_CYC,
  parameter int FLASH_CYC  = BLINK_CYC
) (
  input  wire logic              MCLK,
  input  wire logic              SRST,

  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,

  input  wire logic [N_IN-1:0]   IN_SENSE,
  input  wire logic              FIELD_PWR_OK,
  output logic                   FORCE_LOW,
  output logic                   FORCE_HIGH,
  output logic                   ACTIVE_LED
);

  localparam int BW = $clog2(FLASH_CYC + 1);

  // Control and pass bookkeeping
  logic             test_en;
  logic             go;
  logic             busy;
  logic             sample_low;
  logic             done;
  logic             field_dip;
  logic [CNT_W-1:0] pass_cnt;

  // Input data paths
  logic [N_IN-1:0]  state_filt;
  logic [N_IN-1:0]  hist1;
  logic [N_IN-1:0]  hist2;
  logic [N_IN-1:0]  low_ok;
  logic [N_IN-1:0]  fault;
  logic [N_IN-1:0]  seen_low;
  logic [N_IN-1:0]  seen_high;
  logic [N_IN-1:0]  pass_ok;
  logic [N_IN-1:0]  state_rep;

  // Indicator
  logic [BW-1:0]    blink_cnt;
  logic             any_fault;

  // APB
  logic             access;
  logic             hit;
  logic [31:0]      rd_mux;

  //--------------------------------------------------------------
  // Pass sequencer: drives the forcing circuit, never the field
  //--------------------------------------------------------------
  self_test_seq #(
    .PERIOD (PERIOD_CYC),
    .PHASE  (TEST_CYC)
  ) u_seq (
    .clk        (MCLK),
    .rst        (SRST),
    .enable     (test_en),
    .go         (go),
    .force_low  (FORCE_LOW),
    .force_high (FORCE_HIGH),
    .sample_low (sample_low),
    .done       (done),
    .busy       (busy)
  );

  //--------------------------------------------------------------
  // State filter, frozen while the pass forces the sense circuit
  //--------------------------------------------------------------
  input_filter #(
    .N   (N_IN),
    .CNT (FILTER_CYC)
  ) u_filt (
    .clk  (MCLK),
    .rst  (SRST),
    .hold (busy),
    .raw  (IN_SENSE),
    .filt (state_filt)
  );

  // Without field power every input is open and must read off
  assign state_rep = state_filt & {N_IN{FIELD_PWR_OK}}; // [R7] [R9]

  //--------------------------------------------------------------
  // Forced level checks
  //--------------------------------------------------------------

  // Short sample history; a level counts only if three samples agree,
  // so a single glitch at the end of a phase cannot fake a pass; it leaves that level unseen
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      hist1 <= '0;
      hist2 <= '0;
    end else begin
      hist1 <= IN_SENSE;
      hist2 <= hist1;
    end
  end

  assign seen_low  = ~IN_SENSE & ~hist1 & ~hist2; // [R5]
  assign seen_high = IN_SENSE & hist1 & hist2;    // [R5]

  // Result of the low phase kept until the high phase ends
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      low_ok <= '0;
    end else if (sample_low) begin
      low_ok <= seen_low; // [R1]
    end
  end

  // Any dip of the field supply during a pass spoils that pass
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      field_dip <= 1'b0;
    end else if (!busy) begin
      field_dip <= 1'b0;
    end else if (!FIELD_PWR_OK) begin
      field_dip <= 1'b1;
    end
  end

  assign pass_ok = low_ok & seen_high & {N_IN{FIELD_PWR_OK & ~field_dip}};

  //--------------------------------------------------------------
  // Fault flags
  //--------------------------------------------------------------

  // Supply loss wins at once; otherwise flags change only at pass end,
  // so a fault stays up until a later pass succeeds for that input
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      fault <= '0;
    end else if (!FIELD_PWR_OK) begin
      fault <= '1; // [R10]
    end else if (done) begin
      fault <= ~pass_ok; // [R3] [R8] [R11] [R15]
    end
  end

  assign any_fault = |fault;

  // Completed passes, for software to see the test running
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      pass_cnt <= '0;
    end else if (done) begin
      pass_cnt <= pass_cnt + 1'b1;
    end
  end

  //--------------------------------------------------------------
  // Active indicator
  //--------------------------------------------------------------

  // Blink timer runs only while a fault stands
  always_ff @(posedge MCLK) begin
    if (SRST || !any_fault) begin
      blink_cnt <= '0;
    end else if (blink_cnt == BW'(FLASH_CYC - 1)) begin
      blink_cnt <= '0;
    end else begin
      blink_cnt <= blink_cnt + 1'b1;
    end
  end

  // Steady on when healthy, toggles every blink period on a fault
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ACTIVE_LED <= 1'b1;
    end else if (!any_fault) begin
      ACTIVE_LED <= 1'b1; // [R12]
    end else if (blink_cnt == BW'(FLASH_CYC - 1)) begin
      ACTIVE_LED <= ~ACTIVE_LED; // [R3] [R12]
    end
  end

  //--------------------------------------------------------------
  // APB slave
  //--------------------------------------------------------------

  // One wait state: the answer is registered, so it lands a cycle
  // after the access phase opens
  assign access = PSEL & PENABLE & ~PREADY;

  always_comb begin
    hit    = 1'b1;
    rd_mux = '0;
    unique case (PADDR)
      A_STATE_LO: rd_mux[WORD_W-1:0] = pack_word(state_rep, 1'b0); // [R6] [R13] [R14]
      A_STATE_HI: rd_mux[WORD_W-1:0] = pack_word(state_rep, 1'b1); // [R6] [R14]
      A_FAULT_LO: rd_mux[WORD_W-1:0] = pack_word(fault, 1'b0);     // [R6] [R13] [R14]
      A_FAULT_HI: rd_mux[WORD_W-1:0] = pack_word(fault, 1'b1);     // [R6] [R14]
      A_CTRL: begin
        rd_mux[CTRL_EN_BIT] = test_en;
      end
      A_STATUS: begin
        rd_mux[ST_BUSY_BIT]                    = busy;
        rd_mux[ST_FIELD_BIT]                   = FIELD_PWR_OK;
        rd_mux[ST_FAULT_BIT]                   = any_fault;
        rd_mux[ST_CNT_LSB +: CNT_W]            = pass_cnt;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Handshake, read data and error answer
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      PREADY  <= 1'b0;
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= access;
      PSLVERR <= access & ~hit;
      if (access && !PWRITE) begin
        PRDATA <= rd_mux;
      end
    end
  end

  // Control register; state and fault words ignore writes
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      test_en <= CTRL_EN_RST;
    end else if (access && PWRITE && PADDR == A_CTRL) begin
      test_en <= PWDATA[CTRL_EN_BIT];
    end
  end

  // Manual pass request, a one-cycle pulse; dropped if a pass is running
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      go <= 1'b0;
    end else begin
      go <= access & PWRITE & (PADDR == A_CTRL) & PWDATA[CTRL_GO_BIT];
    end
  end

endmodule : monitored_input_self_test

// File: tb/monitored_input_self_test_props.sv
// Checker for the monitored input block, bound to its top ports
`timescale 1ns/1ps
module monitored_input_self_test_props import mit_pkg::*; #(
  parameter int PERIOD_CYC = PASS_PERIOD_CYC,
  parameter int TEST_CYC   = PHASE_CYC,
  parameter int FLASH_CYC  = BLINK_CYC
) (
  input wire logic              MCLK,
  input wire logic              SRST,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0]       PRDATA,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  input wire logic              FIELD_PWR_OK,
  input wire logic              FORCE_LOW,
  input wire logic              FORCE_HIGH,
  input wire logic              ACTIVE_LED
);
  int   lo_n;
  int   hi_n;
  int   gap;
  int   led_n;
  int   off_n;
  logic led_q;
  // Phase run lengths, time since a low phase, blink age and supply-loss age
  always_ff @(posedge MCLK) begin
    lo_n  <= FORCE_LOW ? lo_n + 1 : 0;
    hi_n  <= FORCE_HIGH ? hi_n + 1 : 0;
    gap   <= (SRST || FORCE_LOW) ? 0 : gap + 1;
    led_n <= (ACTIVE_LED != led_q) ? 0 : led_n + 1;
    led_q <= ACTIVE_LED;
    off_n <= FIELD_PWR_OK ? 0 : off_n + 1;
  end

  function automatic logic bad_addr(input logic [ADDR_W-1:0] a);
    return a > A_STATUS || a[1:0] != 2'b00;
  endfunction : bad_addr

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  a_force_excl: assert property (!(FORCE_LOW && FORCE_HIGH))
    else $error("both forces active");
  a_low_phase: assert property ($fell(FORCE_LOW) |-> FORCE_HIGH && lo_n == TEST_CYC)
    else $error("low phase wrong");
  a_high_phase: assert property ($fell(FORCE_HIGH) |-> !FORCE_LOW && hi_n == TEST_CYC)
    else $error("high phase wrong");
  a_pass_rate: assert property (gap <= PERIOD_CYC + 3)
    else $error("pass overdue");
  a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("ready timing");
  a_map_error: assert property (PREADY |-> PSLVERR == bad_addr(PADDR))
    else $error("error flag vs address");
  a_fault_loss: assert property (PREADY && !PWRITE && off_n > 2 &&
    (PADDR == A_FAULT_LO || PADDR == A_FAULT_HI) |-> PRDATA == 32'h0000FFFF)
    else $error("faults not all set");
  a_state_loss: assert property (PREADY && !PWRITE && off_n > 2 &&
    (PADDR == A_STATE_LO || PADDR == A_STATE_HI) |-> PRDATA == 32'h00000000)
    else $error("state shown without supply");
  a_blink_rate: assert property (off_n > FLASH_CYC + 4 |-> led_n <= FLASH_CYC)
    else $error("indicator not blinking");
  a_reset_quiet: assert property ($past(SRST) |-> !FORCE_LOW && !FORCE_HIGH && ACTIVE_LED)
    else $error("outputs after reset");

  c_pass: cover property ($fell(FORCE_HIGH));
  c_error: cover property (PREADY && PSLVERR);
  c_loss: cover property (off_n == FLASH_CYC + 8);
endmodule : monitored_input_self_test_props

bind monitored_input_self_test monitored_input_self_test_props #(
  .PERIOD_CYC(PERIOD_CYC), .TEST_CYC(TEST_CYC), .FLASH_CYC(FLASH_CYC)
) u_props (.MCLK(MCLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .FIELD_PWR_OK(FIELD_PWR_OK), .FORCE_LOW(FORCE_LOW), .FORCE_HIGH(FORCE_HIGH),
  .ACTIVE_LED(ACTIVE_LED));

// File: tb/sense_model.sv
// Behavioural front end of the 32 sense circuits facing the block
`timescale 1ns/1ps
module sense_model (
  input  wire logic        clk,
  input  wire logic        force_low,
  input  wire logic        force_high,
  input  wire logic        field_ok,
  input  wire logic        slow,
  input  wire logic [31:0] field,
  input  wire logic [31:0] stuck_lo,
  output logic      [31:0] sense
);
  logic [31:0] lvl;
  logic [31:0] d1;
  logic [31:0] d2;
  logic [31:0] d3;
  // Forcing acts on the sense node only; without supply no level can read high
  assign lvl = force_low ? 32'h0 : (force_high ? {32{field_ok}} : field & {32{field_ok}});
  // Slow circuits answer three cycles late, still well inside a phase
  always_ff @(posedge clk) begin
    d1 <= lvl;
    d2 <= d1;
    d3 <= d2;
  end
  // A broken circuit never reports high; an open input reads low
  assign sense = (slow ? d3 : lvl) & ~stuck_lo;
endmodule : sense_model

// File: tb/monitored_input_self_test_test.sv
// Self-checking bench for the monitored input block
`timescale 1ns/1ps
module monitored_input_self_test_test import mit_pkg::*;;
  logic              MCLK = 1'b0;
  logic              SRST = 1'b1;
  logic              PSEL = 1'b0;
  logic              PENABLE = 1'b0;
  logic              PWRITE = 1'b0;
  logic              FIELD_PWR_OK = 1'b1;
  logic              slow = 1'b0;
  logic [ADDR_W-1:0] PADDR = '0;
  logic [31:0]       PWDATA = '0;
  logic [31:0]       field = '0;
  logic [31:0]       stuck = '0;
  logic [31:0]       PRDATA, IN_SENSE, q;
  logic              PREADY, PSLVERR, FORCE_LOW, FORCE_HIGH, ACTIVE_LED, e;
  int                n_errors = 0;
  int                check_count = 0;
  int                seed = 14;
  int                cyc = 0;

  monitored_input_self_test #(.PERIOD_CYC(2000), .TEST_CYC(20), .FILTER_CYC(8), .FLASH_CYC(16))
    u_monitored_input_self_test (.MCLK(MCLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IN_SENSE(IN_SENSE), .FIELD_PWR_OK(FIELD_PWR_OK),
    .FORCE_LOW(FORCE_LOW), .FORCE_HIGH(FORCE_HIGH), .ACTIVE_LED(ACTIVE_LED));
  sense_model u_sense_model (.clk(MCLK), .force_low(FORCE_LOW), .force_high(FORCE_HIGH),
    .field_ok(FIELD_PWR_OK), .slow(slow), .field(field), .stuck_lo(stuck), .sense(IN_SENSE));

  // 40 MHz clock
  initial forever #12.5 MCLK = ~MCLK;

  // Cut a hang short well past the expected run length
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end

  task final_report;
    if (n_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until ready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    @(posedge MCLK);
    while (PREADY !== 1'b1 && n < 20) begin
      n++;
      @(posedge MCLK);
    end
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask : rd

  // Input 1 goes to bit 15 of the low word, input 17 to bit 15 of the high word
  function automatic logic [31:0] wexp(input logic [31:0] v, input int hi);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) r[15-i] = v[16*hi+i];
    return r;
  endfunction : wexp

  // Start a pass now, wait for its end, then let the filter settle
  task pass;
    int n;
    n = 0;
    apb(1'b1, A_CTRL, 32'h3);
    while (FORCE_HIGH !== 1'b1 && n < 200) begin
      n++;
      @(posedge MCLK);
    end
    while (FORCE_HIGH === 1'b1 && n < 200) begin
      n++;
      @(posedge MCLK);
    end
    repeat (14) @(posedge MCLK);
  endtask : pass

  // Blinking is seen as any change over a few blink periods
  task led(input logic [31:0] x);
    int   c;
    logic p;
    c = 0;
    p = ACTIVE_LED;
    repeat (40) begin
      @(posedge MCLK);
      if (ACTIVE_LED !== p) c++;
      p = ACTIVE_LED;
    end
    chk({31'h0, c > 0}, x);
  endtask : led

  initial begin
    int n;
    n = 0;
    repeat (12) @(posedge MCLK);
    SRST <= 1'b0;
    @(posedge MCLK);
    chk({31'h0, ACTIVE_LED}, 32'h1);
    rd(A_CTRL, 32'h1);
    for (int a = 0; a < 4; a++) rd(8'(4 * a), 32'h0);
    // Random field patterns, some with a broken circuit, some with slow circuits
    for (int k = 0; k < 6; k++) begin
      field <= $random(seed);
      stuck <= (k % 3 == 1) ? 32'h1 << ($random(seed) & 31) : 32'h0;
      slow <= k[0];
      pass();
      for (int h = 0; h < 2; h++) begin
        rd(8'(4 * h), wexp(field & ~stuck, h));
        rd(8'(8 + 4 * h), wexp(stuck, h));
      end
      led({31'h0, stuck != 0});
    end
    // Short glitch on input 2 must not reach the state word
    field <= 32'h1;
    repeat (12) @(posedge MCLK);
    field <= 32'h3;
    repeat (3) @(posedge MCLK);
    field <= 32'h1;
    repeat (12) @(posedge MCLK);
    rd(A_STATE_LO, 32'h8000);
    // Reads in mid-pass never show the forced levels
    apb(1'b1, A_CTRL, 32'h3);
    rd(A_STATE_LO, 32'h8000);
    while (FORCE_HIGH !== 1'b1 && n < 100) begin
      n++;
      @(posedge MCLK);
    end
    rd(A_STATE_LO, 32'h8000);
    // Unmapped address errors; writes to word registers are ignored
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    apb(1'b1, A_STATE_LO, 32'hFFFF);
    rd(A_STATE_LO, 32'h8000);
    // Supply loss flags every input, then a good pass clears them
    FIELD_PWR_OK <= 1'b0;
    repeat (3) @(posedge MCLK);
    for (int a = 0; a < 4; a++) rd(8'(4 * a), a < 2 ? 32'h0 : 32'hFFFF);
    led(32'h1);
    FIELD_PWR_OK <= 1'b1;
    pass();
    rd(A_FAULT_LO, 32'h0);
    rd(A_FAULT_HI, 32'h0);
    led(32'h0);
    // A pass must come by itself within one period
    n = 0;
    while (FORCE_LOW !== 1'b1 && n < 2100) begin
      n++;
      @(posedge MCLK);
    end
    chk({31'h0, FORCE_LOW}, 32'h1);
    // Nine completed passes so far; then a disabled block ignores a manual start
    repeat (50) @(posedge MCLK);
    rd(A_STATUS, (32'd9 << ST_CNT_LSB) | (32'h1 << ST_FIELD_BIT));
    apb(1'b1, A_CTRL, 32'h2);
    rd(A_CTRL, 32'h0);
    repeat (4) @(posedge MCLK);
    chk({31'h0, FORCE_LOW}, 32'h0);
    final_report();
  end
endmodule : monitored_input_self_test_test
